// file: logic/flash_status_pkg.sv
/*
 Shared constants and types for the host-side flash status controller.
 Assumes a 25 MHz system clock and an x16 two-die flash on an asynchronous bus.
*/
package flash_status_pkg;

   // Clock and bus timing
   localparam int CLK_PERIOD_NS      = 40;
   localparam int READ_ACCESS_NS     = 105;
   localparam int READ_ACCESS_CYCLES = (READ_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int WRITE_PULSE_NS     = 40;
   localparam int WRITE_PULSE_CYCLES = (WRITE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int SYNC_STAGES        = 3;

   // Command cycle addresses and codes
   localparam logic [11:0] UNLOCK_ADDR_1    = 12'h0555;
   localparam logic [11:0] UNLOCK_ADDR_2    = 12'h02AA;
   localparam logic [15:0] CODE_UNLOCK_1    = 16'h00AA;
   localparam logic [15:0] CODE_UNLOCK_2    = 16'h0055;
   localparam logic [15:0] CODE_READ_RESET  = 16'h00F0;
   localparam logic [15:0] CODE_READ_STATUS = 16'h0070;

   // Operation status register fields
   localparam int READY_FLAG_POS       = 7;
   localparam int ERASE_CHECK_FAIL_POS = 5;
   localparam int PROGRAM_FAIL_POS     = 4;
   localparam int BUFFER_ABORT_POS     = 3;
   localparam int LOCKED_BLOCK_POS     = 1;
   localparam logic [15:0] STATUS_VALID_MASK = 16'h00FE;
   localparam logic [15:0] STATUS_BUSY_MASK  = 16'h0080;

   // Data polling fields
   localparam int COMPLETION_POS   = 7;
   localparam int POLL_ERROR_POS   = 5;
   localparam int ABORT_POLL_POS   = 1;
   localparam logic [15:0] POLL_VALID_MASK = 16'h00EE;

   typedef enum logic [2:0] {
      CMD_WRITE,
      CMD_POLL,
      CMD_READ_STATUS,
      CMD_READ_RESET,
      CMD_FULL_RESET
   } cmd_kind_t;

   typedef enum logic [2:0] {
      RES_OK,
      RES_BUSY,
      RES_FAILED,
      RES_ABORTED,
      RES_TIMEOUT,
      RES_REFUSED
   } outcome_t;

   typedef struct packed {
      cmd_kind_t   kind;
      logic [15:0] wdata;
   } req_t;

   typedef struct packed {
      outcome_t    outcome;
      logic [15:0] data;
   } result_t;

   typedef struct packed {
      logic        ce_n;
      logic        oe_n;
      logic        we_n;
      logic [15:0] dq_out;
      logic        dq_oe;
   } pins_t;

   localparam pins_t PINS_IDLE = '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1,
                                   dq_out: 16'h0000, dq_oe: 1'b0};

endpackage

// file: logic/flash_bus_cycle.sv
/*
 One asynchronous bus read or write cycle on the flash pins.
 Assumes the data inputs come straight from the pins, outside this clock domain.
*/
module flash_bus_cycle #(
   parameter int ADDR_W = 27
) (
   // Clock and reset
   input  wire logic                     clock,
   input  wire logic                     rst_n,
   // Request
   input  wire logic                     start,
   input  wire logic                     write,
   input  wire logic [ADDR_W-1:0]        addr,
   input  wire logic [15:0]              wdata,
   // Answer
   output logic                          done,
   output logic [15:0]                   rdata,
   // Flash pins
   output flash_status_pkg::pins_t       pins,
   output logic [ADDR_W-1:0]             pin_addr,
   input  wire logic [15:0]              dq_in
);

   typedef enum logic [1:0] {PH_IDLE, PH_SETUP, PH_STROBE, PH_HOLD} phase_t;

   typedef struct packed {
      phase_t                  phase;
      logic                    wr;
      logic [3:0]              cnt;
      flash_status_pkg::pins_t pins;
      logic [ADDR_W-1:0]       addr;
      logic [15:0]             rdata;
      logic                    done;
      logic [15:0]             s1;
      logic [15:0]             s2;
      logic [15:0]             s3;
   } state_t;

   localparam state_t RESET_STATE = '{phase: PH_IDLE, pins: flash_status_pkg::PINS_IDLE,
                                     default: '0};

   state_t s_q;
   state_t s_d;

   always_comb begin
      s_d      = s_q;
      s_d.done = 1'b0;
      s_d.s1   = dq_in;
      s_d.s2   = s_q.s1;
      s_d.s3   = s_q.s2;
      case (s_q.phase)
         PH_IDLE: begin
            if (start) begin
               s_d.addr      = addr;
               s_d.wr        = write;
               s_d.pins.ce_n = 1'b0;
               s_d.phase     = PH_SETUP;
               if (write) begin
                  s_d.pins.dq_out = wdata;
                  s_d.pins.dq_oe  = 1'b1;
                  s_d.cnt         = 4'd0;
               end else begin
                  s_d.pins.oe_n = 1'b0;
                  s_d.cnt = 4'(flash_status_pkg::READ_ACCESS_CYCLES
                               + flash_status_pkg::SYNC_STAGES);
               end
            end
         end
         PH_SETUP: begin
            if (s_q.cnt != 4'd0) begin
               s_d.cnt = s_q.cnt - 4'd1;
            end else if (s_q.wr) begin
               s_d.pins.we_n = 1'b0;
               s_d.cnt       = 4'(flash_status_pkg::WRITE_PULSE_CYCLES - 1);
               s_d.phase     = PH_STROBE;
            end else if (s_q.s2 == s_q.s3) begin
               // Data counts once the last two sync stages agree
               s_d.rdata     = s_q.s3;
               s_d.pins      = flash_status_pkg::PINS_IDLE;
               s_d.done      = 1'b1;
               s_d.phase     = PH_IDLE;
            end
         end
         PH_STROBE: begin
            if (s_q.cnt != 4'd0) begin
               s_d.cnt = s_q.cnt - 4'd1;
            end else begin
               s_d.pins.we_n = 1'b1;
               s_d.phase     = PH_HOLD;
            end
         end
         PH_HOLD: begin
            s_d.pins  = flash_status_pkg::PINS_IDLE;
            s_d.done  = 1'b1;
            s_d.phase = PH_IDLE;
         end
         default: begin
            s_d = RESET_STATE;
         end
      endcase
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         s_q <= RESET_STATE;
      end else begin
         s_q <= s_d;
      end
   end

   assign done     = s_q.done;
   assign rdata    = s_q.rdata;
   assign pins     = s_q.pins;
   assign pin_addr = s_q.addr;

endmodule

// file: logic/flash_status_host.sv
/*
 Host controller that polls and reads operation status of a two-die flash.
 Assumes the flash sits on the pins below and the user sequences the command
 cycles that start program or erase through the plain write command.
*/
module flash_status_host #(
   parameter int ADDR_W    = 27,
   parameter int MAX_POLLS = 65536
) (
   // Clock and reset
   input  wire logic                     clock,
   input  wire logic                     rst_n,
   // User request
   input  wire logic                     req_valid,
   input  flash_status_pkg::req_t        req,
   input  wire logic [ADDR_W-1:0]        req_addr,
   output logic                          req_ready,
   // User answer
   output logic                          resp_valid,
   output flash_status_pkg::result_t     resp,
   // Controller state
   output logic                          need_read_reset,
   output logic                          need_full_reset,
   output logic                          die_busy,
   output logic                          die_busy_sel,
   output logic                          ready_busy_seen,
   // Flash pins
   output flash_status_pkg::pins_t       flash_pins,
   output logic [ADDR_W-1:0]             flash_addr,
   input  wire logic [15:0]              dq_in,
   input  wire logic                     ready_busy_in
);

   localparam int POLL_W = $clog2(MAX_POLLS + 1);

   if (ADDR_W < 13 || MAX_POLLS < 1) begin : g_bad_params
      $error("flash_status_host: ADDR_W must be at least 13 and MAX_POLLS at least 1");
   end

   typedef enum logic [1:0] {ST_IDLE, ST_STEP, ST_WAIT} fsm_t;
   typedef enum logic [1:0] {LK_NONE, LK_NEED_RESET, LK_NEED_FULL} lock_t;

   typedef struct packed {
      fsm_t                        fsm;
      lock_t                       lock;
      flash_status_pkg::cmd_kind_t kind;
      logic [ADDR_W-1:0]           addr;
      logic [15:0]                 wdata;
      logic [1:0]                  step;
      logic [POLL_W-1:0]           polls;
      logic                        busy_valid;
      logic                        busy_die;
      logic                        start;
      logic                        bus_wr;
      logic [ADDR_W-1:0]           bus_addr;
      logic [15:0]                 bus_wdata;
      logic                        req_ready;
      logic                        resp_valid;
      flash_status_pkg::result_t   resp;
      logic                        rb1;
      logic                        rb2;
      logic                        rb3;
      logic                        rb_level;
   } state_t;

   localparam state_t RESET_STATE = '{fsm: ST_IDLE, lock: LK_NONE,
                                     kind: flash_status_pkg::CMD_WRITE,
                                     rb_level: 1'b1, default: '0};

   state_t s_q;
   state_t s_d;

   logic        bus_done;
   logic [15:0] bus_rdata;

   flash_bus_cycle #(
      .ADDR_W (ADDR_W)
   ) u_bus (
      .clock    (clock),
      .rst_n    (rst_n),
      .start    (s_q.start),
      .write    (s_q.bus_wr),
      .addr     (s_q.bus_addr),
      .wdata    (s_q.bus_wdata),
      .done     (bus_done),
      .rdata    (bus_rdata),
      .pins     (flash_pins),
      .pin_addr (flash_addr),
      .dq_in    (dq_in)
   );

   // Command cycle address inside the die that the request selects
   function automatic logic [ADDR_W-1:0] die_addr(input logic die, input logic [11:0] low);
      logic [ADDR_W-1:0] a;
      a             = '0;
      a[ADDR_W-1]   = die;
      a[11:0]       = low;
      return a;
   endfunction

   always_comb begin
      logic        refuse;
      logic        die;
      logic [15:0] masked;
      refuse       = 1'b0;
      die          = s_q.addr[ADDR_W-1];
      masked       = 16'h0000;
      s_d          = s_q;
      s_d.start    = 1'b0;
      s_d.resp_valid = 1'b0;
      s_d.rb1      = ready_busy_in;
      s_d.rb2      = s_q.rb1;
      s_d.rb3      = s_q.rb2;
      if (s_q.rb2 == s_q.rb3) begin
         s_d.rb_level = s_q.rb3;
      end
      case (s_q.fsm)
         ST_IDLE: begin
            if (req_valid && s_q.req_ready) begin
               refuse = (s_q.lock == LK_NEED_RESET)
                        && (req.kind != flash_status_pkg::CMD_READ_RESET)
                        && (req.kind != flash_status_pkg::CMD_FULL_RESET);
               if (s_q.lock == LK_NEED_FULL && req.kind != flash_status_pkg::CMD_FULL_RESET) begin
                  refuse = 1'b1;
               end
               if (req.kind == flash_status_pkg::CMD_WRITE && s_q.busy_valid
                   && req_addr[ADDR_W-1] != s_q.busy_die) begin
                  refuse = 1'b1;
               end
               if (refuse) begin
                  s_d.resp_valid   = 1'b1;
                  s_d.resp.outcome = flash_status_pkg::RES_REFUSED;
                  s_d.resp.data    = 16'h0000;
               end else begin
                  s_d.kind  = req.kind;
                  s_d.addr  = req_addr;
                  s_d.wdata = req.wdata;
                  s_d.step  = 2'd0;
                  s_d.polls = '0;
                  s_d.fsm   = ST_STEP;
               end
            end
         end
         ST_STEP: begin
            s_d.start     = 1'b1;
            s_d.bus_wr    = 1'b1;
            s_d.bus_addr  = s_q.addr;
            s_d.bus_wdata = s_q.wdata;
            s_d.fsm       = ST_WAIT;
            case (s_q.kind)
               flash_status_pkg::CMD_READ_RESET: begin
                  s_d.bus_wdata = flash_status_pkg::CODE_READ_RESET;
               end
               flash_status_pkg::CMD_FULL_RESET: begin
                  if (s_q.step == 2'd0) begin
                     s_d.bus_addr  = die_addr(die, flash_status_pkg::UNLOCK_ADDR_1);
                     s_d.bus_wdata = flash_status_pkg::CODE_UNLOCK_1;
                  end else if (s_q.step == 2'd1) begin
                     s_d.bus_addr  = die_addr(die, flash_status_pkg::UNLOCK_ADDR_2);
                     s_d.bus_wdata = flash_status_pkg::CODE_UNLOCK_2;
                  end else begin
                     s_d.bus_wdata = flash_status_pkg::CODE_READ_RESET;
                  end
               end
               flash_status_pkg::CMD_READ_STATUS: begin
                  if (s_q.step == 2'd0) begin
                     s_d.bus_addr  = die_addr(die, flash_status_pkg::UNLOCK_ADDR_1);
                     s_d.bus_wdata = flash_status_pkg::CODE_READ_STATUS;
                  end else begin
                     s_d.bus_wr = 1'b0;
                  end
               end
               flash_status_pkg::CMD_POLL: begin
                  s_d.bus_wr = 1'b0;
               end
               default: begin
                  s_d.bus_wr = 1'b1;
               end
            endcase
         end
         ST_WAIT: begin
            if (bus_done) begin
               s_d.fsm          = ST_IDLE;
               s_d.resp_valid   = 1'b1;
               s_d.resp.outcome = flash_status_pkg::RES_OK;
               s_d.resp.data    = 16'h0000;
               case (s_q.kind)
                  flash_status_pkg::CMD_WRITE: begin
                     s_d.busy_valid = 1'b1;
                     s_d.busy_die   = die;
                  end
                  flash_status_pkg::CMD_READ_RESET: begin
                     s_d.lock       = LK_NONE;
                     s_d.busy_valid = 1'b0;
                  end
                  flash_status_pkg::CMD_FULL_RESET: begin
                     if (s_q.step != 2'd2) begin
                        s_d.step       = s_q.step + 2'd1;
                        s_d.fsm        = ST_STEP;
                        s_d.resp_valid = 1'b0;
                     end else begin
                        s_d.lock       = LK_NONE;
                        s_d.busy_valid = 1'b0;
                     end
                  end
                  flash_status_pkg::CMD_READ_STATUS: begin
                     if (s_q.step == 2'd0) begin
                        s_d.step       = 2'd1;
                        s_d.fsm        = ST_STEP;
                        s_d.resp_valid = 1'b0;
                     end else if (!bus_rdata[flash_status_pkg::READY_FLAG_POS]) begin
                        s_d.resp.data    = bus_rdata & flash_status_pkg::STATUS_BUSY_MASK;
                        s_d.resp.outcome = flash_status_pkg::RES_BUSY;
                     end else begin
                        masked        = bus_rdata & flash_status_pkg::STATUS_VALID_MASK;
                        s_d.resp.data = masked;
                        if (masked[flash_status_pkg::BUFFER_ABORT_POS]) begin
                           s_d.resp.outcome = flash_status_pkg::RES_ABORTED;
                           s_d.lock         = LK_NEED_FULL;
                        end else if (masked[flash_status_pkg::ERASE_CHECK_FAIL_POS]
                                     || masked[flash_status_pkg::PROGRAM_FAIL_POS]
                                     || masked[flash_status_pkg::LOCKED_BLOCK_POS]) begin
                           s_d.resp.outcome = flash_status_pkg::RES_FAILED;
                           s_d.lock         = LK_NEED_RESET;
                        end else begin
                           s_d.busy_valid = 1'b0;
                        end
                     end
                  end
                  flash_status_pkg::CMD_POLL: begin
                     masked        = bus_rdata & flash_status_pkg::POLL_VALID_MASK;
                     s_d.resp.data = masked;
                     if (masked[flash_status_pkg::COMPLETION_POS]
                         == s_q.wdata[flash_status_pkg::COMPLETION_POS]) begin
                        s_d.busy_valid = 1'b0;
                     end else if (s_q.step == 2'd1) begin
                        s_d.resp.outcome = flash_status_pkg::RES_FAILED;
                        s_d.lock         = LK_NEED_RESET;
                     end else if (masked[flash_status_pkg::POLL_ERROR_POS]) begin
                        s_d.step       = 2'd1;
                        s_d.fsm        = ST_STEP;
                        s_d.resp_valid = 1'b0;
                     end else if (masked[flash_status_pkg::ABORT_POLL_POS]) begin
                        s_d.resp.outcome = flash_status_pkg::RES_ABORTED;
                        s_d.lock         = LK_NEED_FULL;
                     end else if (s_q.polls == POLL_W'(MAX_POLLS - 1)) begin
                        s_d.resp.outcome = flash_status_pkg::RES_TIMEOUT;
                     end else begin
                        s_d.polls      = s_q.polls + POLL_W'(1);
                        s_d.fsm        = ST_STEP;
                        s_d.resp_valid = 1'b0;
                     end
                  end
                  default: begin
                     s_d.resp.outcome = flash_status_pkg::RES_OK;
                  end
               endcase
            end
         end
         default: begin
            s_d = RESET_STATE;
         end
      endcase
      s_d.req_ready = (s_d.fsm == ST_IDLE);
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         s_q <= RESET_STATE;
      end else begin
         s_q <= s_d;
      end
   end

   assign req_ready       = s_q.req_ready;
   assign resp_valid      = s_q.resp_valid;
   assign resp            = s_q.resp;
   assign need_read_reset = (s_q.lock == LK_NEED_RESET);
   assign need_full_reset = (s_q.lock == LK_NEED_FULL);
   assign die_busy        = s_q.busy_valid;
   assign die_busy_sel    = s_q.busy_die;
   assign ready_busy_seen = s_q.rb_level;

endmodule

// file: tb/flash_status_host_asserts.sv
/*
 Checker for flash_status_host: handshake, refusals, locks and pin cycles.
 Bound to the host below; sees its ports only.
*/
module flash_status_host_asserts #(parameter int ADDR_W = 27, parameter int MAX_POLLS = 8) (
   // Clock, reset
   input wire logic                  clock,
   input wire logic                  rst_n,
   // User side
   input wire logic                  req_valid,
   input flash_status_pkg::req_t     req,
   input wire logic [ADDR_W-1:0]     req_addr,
   input wire logic                  req_ready,
   input wire logic                  resp_valid,
   input flash_status_pkg::result_t  resp,
   // State, pins
   input wire logic                  need_read_reset,
   input wire logic                  need_full_reset,
   input wire logic                  die_busy,
   input wire logic                  die_busy_sel,
   input flash_status_pkg::pins_t    flash_pins
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge clock); endclocking
   default disable iff (!rst_n);
   sequence s_take; req_valid && req_ready; endsequence
   sequence s_refused; resp_valid && resp.outcome == flash_status_pkg::RES_REFUSED; endsequence
   AST_REFUSE_FULL:
   assert property (s_take ##0 (need_full_reset && req.kind != flash_status_pkg::CMD_FULL_RESET)
      |=> s_refused ##0 flash_pins.ce_n) else $error("abort lock not refusing");
   AST_REFUSE_READ:
   assert property (s_take ##0 (need_read_reset && req.kind == flash_status_pkg::CMD_WRITE)
      |=> s_refused) else $error("error lock not refusing");
   AST_OTHER_DIE:
   assert property (s_take ##0 (!need_read_reset && !need_full_reset && die_busy &&
      req.kind == flash_status_pkg::CMD_WRITE && req_addr[ADDR_W-1] != die_busy_sel)
      |=> s_refused) else $error("write to idle die while other busy");
   AST_ANSWER_BOUND:
   assert property (s_take |-> ##[1:1000] resp_valid) else $error("no answer");
   AST_READY_HELD:
   assert property (s_take |=> !req_ready || resp_valid) else $error("second request taken");
   AST_FAIL_LOCK:
   assert property (resp_valid && resp.outcome == flash_status_pkg::RES_FAILED
      |-> ##[0:1] need_read_reset) else $error("failure without read reset lock");
   AST_ABORT_LOCK:
   assert property (resp_valid && resp.outcome == flash_status_pkg::RES_ABORTED
      |-> ##[0:1] need_full_reset) else $error("abort without full reset lock");
   AST_STATUS_BYTE:
   assert property (resp_valid && resp.outcome != flash_status_pkg::RES_REFUSED &&
      resp.outcome != flash_status_pkg::RES_OK |-> resp.data[15:8] == 8'h00 && !resp.data[0])
      else $error("reserved status bits set");
   AST_BUSY_DATA:
   assert property (resp_valid && resp.outcome == flash_status_pkg::RES_BUSY
      |-> resp.data == 16'h0000) else $error("busy status not cleared");
   AST_WRITE_PULSE:
   assert property ($fell(flash_pins.we_n) |-> !flash_pins.ce_n && flash_pins.dq_oe
      ##1 flash_pins.we_n && !flash_pins.ce_n) else $error("bad write pulse");
   AST_NO_CLASH:
   assert property (!flash_pins.oe_n |-> !flash_pins.dq_oe) else $error("driving during read");
endmodule

bind flash_status_host flash_status_host_asserts #(.ADDR_W(ADDR_W), .MAX_POLLS(MAX_POLLS))
   u_asserts (.clock, .rst_n, .req_valid, .req, .req_addr, .req_ready, .resp_valid, .resp,
   .need_read_reset, .need_full_reset, .die_busy, .die_busy_sel, .flash_pins);

// file: tb/flash_die_model.sv
/*
 Behavioural two-die flash: polling word, status register, ready/busy pin.
 Driven by the host pins; the bench picks fault, erase and busy length.
*/
module flash_die_model #(parameter int ADDR_W = 27) (
   // Pins
   input flash_status_pkg::pins_t    pins,
   input wire logic [ADDR_W-1:0]     addr,
   output logic [15:0]               dq,
   output logic                      rb_low,
   // Scenario
   input wire logic [1:0]            fault,
   input wire logic                  erase,
   input wire logic [3:0]            busy_reads
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [15:0] word_q, last_q, val;
   logic [7:0]  st_q, st;
   logic [3:0]  left_q;
   logic        die_q, tog_q, err, rd, sel;
   logic        act_q = 1'b0;
   logic        smode_q = 1'b0;
   assign rd  = !pins.ce_n && !pins.oe_n;
   assign sel = act_q && addr[ADDR_W-1] == die_q;
   assign err = act_q && left_q == 4'h0 && fault != 2'h0;
   assign rb_low = act_q && !err;
   assign st = !act_q ? 8'h80 : !err ? 8'h00 : {2'b10, fault == 2'h1 && erase,
      fault == 2'h2 || (fault == 2'h1 && !erase), fault == 2'h2, 1'b0, fault == 2'h3, 1'b0};
   // same inverse bit for a chip check; other addresses read array
   always_comb begin
      if (smode_q) val = {8'h00, st_q};
      else if (sel) val = {8'h00, left_q == 0 && fault == 0 ? erase | word_q[7] : !erase & !word_q[7],
         tog_q, err && fault != 2'h2, 1'b0, erase, erase & tog_q, err && fault == 2'h2, 1'b0};
      else val = {addr[7:0], ~addr[7:0]};
      dq = rd ? val : ~last_q;
   end
   always @(posedge pins.we_n) begin
      if (!pins.ce_n && pins.dq_out == 16'h0070) begin
         st_q <= st;
         smode_q <= 1'b1;
      end else if (!pins.ce_n && pins.dq_out == 16'h00F0) act_q <= 1'b0;
      else if (!pins.ce_n && pins.dq_out[8]) begin
         act_q <= 1'b1;
         tog_q <= 1'b0;
         die_q <= addr[ADDR_W-1];
         word_q <= pins.dq_out;
         left_q <= busy_reads;
      end
   end
   always @(negedge rd) begin
      last_q <= val;
      if (smode_q) smode_q <= 1'b0;
      else if (sel) begin
         tog_q <= !tog_q;
         if (left_q != 4'h0) left_q <= left_q - 4'h1;
         else if (fault == 2'h0) act_q <= 1'b0;
      end
   end
endmodule

// file: tb/tb_top.sv
/*
 Self-checking bench: flash_status_host against the behavioural flash model.
 Assumes the checker file is compiled in and binds itself to the host.
*/
module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int AW = 27;
   logic clock = 1'b0, rst_n = 1'b0, req_valid = 1'b0, erase = 1'b0, rb_low, req_ready;
   logic resp_valid, nrr, nfr, rb_seen, dbusy;
   logic [1:0] f, fault = 2'h0;
   logic [3:0] busy_reads = 4'h0;
   logic [15:0] dq, w;
   logic [AW-1:0] req_addr = '0, faddr, a;
   flash_status_pkg::req_t req = '0;
   flash_status_pkg::result_t resp;
   flash_status_pkg::pins_t pins;
   int err_count = 0, cmp_count = 0, cyc = 0;
   flash_status_host #(.ADDR_W(AW), .MAX_POLLS(6)) u_dut (.clock, .rst_n, .req_valid, .req,
      .req_addr, .req_ready, .resp_valid, .resp, .need_read_reset(nrr), .need_full_reset(nfr),
      .die_busy(dbusy), .die_busy_sel(), .ready_busy_seen(rb_seen), .flash_pins(pins),
      .flash_addr(faddr), .dq_in(dq), .ready_busy_in(!rb_low));
   flash_die_model #(.ADDR_W(AW)) u_flash (.pins, .addr(faddr), .dq, .rb_low, .fault, .erase,
      .busy_reads);
   initial forever #20 clock = !clock;
   task automatic test_done();
      $display("Compares %0d, errors %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   always @(posedge clock) if (++cyc == 20000) begin
      err_count++;
      test_done();
   end
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         err_count++;
         $display("Error %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic op(input flash_status_pkg::cmd_kind_t k, input logic [15:0] wd,
      input logic [AW-1:0] ad, input flash_status_pkg::outcome_t eo, input logic [15:0] ed);
      @(posedge clock);
      #1 req_valid = 1'b1;
      req = '{kind: k, wdata: wd};
      req_addr = ad;
      do @(negedge clock); while (req_ready !== 1'b1);
      @(posedge clock);
      #1 req_valid = 1'b0;
      do @(negedge clock); while (resp_valid !== 1'b1);
      check(16'(resp.outcome), 16'(eo));
      if (k != flash_status_pkg::CMD_WRITE) check(resp.data & 16'h00A2, ed & 16'h00A2);
   endtask
   initial begin
      void'($urandom(32'h4590_2b5a));
      repeat (20) @(posedge clock);
      #1 rst_n = 1'b1;
      for (int i = 0; i < 17; i++) begin
         @(posedge clock);
         #1 f = i[1:0];
         fault = i < 16 ? f : 2'h0;
         erase = i[2];
         busy_reads = i == 16 ? 4'hF : i[3] ? 4'($urandom_range(3)) : 4'h0;
         a = AW'($urandom);
         w = 16'($urandom) | 16'h0100;
         op(flash_status_pkg::CMD_WRITE, w, a, flash_status_pkg::RES_OK, 0);
         repeat (5) @(negedge clock);
         check(16'(rb_seen), 16'(fault != 0 && busy_reads == 0));
         check(16'(dbusy), 16'h0001);
         if (i == 16) op(flash_status_pkg::CMD_POLL, w, a, flash_status_pkg::RES_TIMEOUT,
            {8'h00, !w[7], 7'h00});
         else if (!i[3]) op(flash_status_pkg::CMD_READ_STATUS, 0, a, f == 0 ?
            flash_status_pkg::RES_BUSY : f == 2 ? flash_status_pkg::RES_ABORTED :
            flash_status_pkg::RES_FAILED, f == 2 ? 16'h0098 : f == 3 ? 16'h0082 :
            f == 0 ? 16'h0000 : erase ? 16'h00A0 : 16'h0090);
         else op(flash_status_pkg::CMD_POLL, {8'h00, erase | w[7], 7'h00}, a, f == 0 ?
            flash_status_pkg::RES_OK : f == 2 ? flash_status_pkg::RES_ABORTED :
            flash_status_pkg::RES_FAILED, {8'h00, f == 0 ? erase | w[7] : !erase & !w[7],
            1'b0, f[0], 3'h0, f == 2, 1'b0});
         if (fault == 0 && !i[3] || i == 16) op(flash_status_pkg::CMD_WRITE, w,
            a ^ {1'b1, 26'h0}, flash_status_pkg::RES_REFUSED, 0);
         if (i == 16) op(flash_status_pkg::CMD_READ_RESET, 0, a, flash_status_pkg::RES_OK, 0);
         else if (f == 0 && !i[3]) op(flash_status_pkg::CMD_POLL, {8'h00, erase | w[7], 7'h00},
            a, flash_status_pkg::RES_OK, {8'h00, erase | w[7], 7'h00});
         else if (f != 0) begin
            op(flash_status_pkg::CMD_WRITE, w, a, flash_status_pkg::RES_REFUSED, 0);
            check(16'({nfr, nrr}), f == 2 ? 16'h0002 : 16'h0001);
            op(f == 2 ? flash_status_pkg::CMD_FULL_RESET : flash_status_pkg::CMD_READ_RESET, 0, a,
               flash_status_pkg::RES_OK, 0);
         end
         op(flash_status_pkg::CMD_READ_STATUS, 0, a, flash_status_pkg::RES_OK, 16'h0080);
      end
      test_done();
   end
endmodule
